// ===== rtl/fps_pkg.sv
// Shared constants and types for the host-side flash command sequencer.
// Assumes a 16-bit parallel NOR flash, word addressing, and a 20 MHz host clock.
package fps_pkg;

  // ****************************************
  // Widths and clock
  // ****************************************
  localparam int ADDR_W        = 26;
  localparam int DATA_W        = 16;
  localparam int SECT_W        = 10;
  localparam int CLK_PERIOD_NS = 50;

  // Least times round up to whole cycles, never below one
  function automatic int ns_to_min_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // ****************************************
  // Timing
  // ****************************************
  localparam int T_SUSPEND_MAX_NS = 15000;
  localparam int T_WE_PULSE_NS    = 50;
  localparam int T_WE_HIGH_NS     = 50;
  localparam int T_READ_ACC_NS    = 110;
  localparam int T_HV_SETUP_NS    = 250;
  localparam int SYNC_STAGES      = 2;

  localparam logic [8:0] SUSPEND_CYC = 9'(ns_to_min_cyc(T_SUSPEND_MAX_NS));
  localparam logic [8:0] HV_CYC      = 9'(ns_to_min_cyc(T_HV_SETUP_NS));
  localparam logic [3:0] WP_CYC      = 4'(ns_to_min_cyc(T_WE_PULSE_NS));
  localparam logic [3:0] WPH_CYC     = 4'(ns_to_min_cyc(T_WE_HIGH_NS));
  localparam logic [3:0] ACC_CYC     = 4'(ns_to_min_cyc(T_READ_ACC_NS) + SYNC_STAGES);

  // ****************************************
  // Command words and unlock addresses
  // ****************************************
  localparam logic [DATA_W-1:0] CMD_UNLOCK1    = 16'h00aa;
  localparam logic [DATA_W-1:0] CMD_UNLOCK2    = 16'h0055;
  localparam logic [DATA_W-1:0] CMD_BYP_ENTRY  = 16'h0020;
  localparam logic [DATA_W-1:0] CMD_PROG_SETUP = 16'h00a0;
  localparam logic [DATA_W-1:0] CMD_EXIT1      = 16'h0090;
  localparam logic [DATA_W-1:0] CMD_EXIT2      = 16'h0000;
  localparam logic [DATA_W-1:0] CMD_SUSPEND    = 16'h00b0;
  localparam logic [DATA_W-1:0] CMD_RESUME     = 16'h0030;
  localparam logic [DATA_W-1:0] CMD_RESET      = 16'h00f0;
  localparam logic [ADDR_W-1:0] ADDR_UNLOCK1   = 26'h0000555;
  localparam logic [ADDR_W-1:0] ADDR_UNLOCK2   = 26'h00002aa;

  localparam logic [3:0] ACCEL_USE_MAX = 4'ha;
  localparam logic [3:0] ACCEL_USE_RST = 4'h0;
  localparam int         DQ_POLL_BIT   = 7;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    OP_READ       = 3'b000,
    OP_BYP_ENTER  = 3'b001,
    OP_BYP_PROG   = 3'b010,
    OP_BYP_EXIT   = 3'b011,
    OP_SUSPEND    = 3'b100,
    OP_RESUME     = 3'b101,
    OP_RESET3     = 3'b110,
    OP_ACCEL_PROG = 3'b111
  } fps_op_t;

  typedef struct packed {
    logic              valid;
    fps_op_t           op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fps_req_t;

  typedef struct packed {
    logic              done;
    logic              err;
    logic [DATA_W-1:0] rdata;
  } fps_rsp_t;

  typedef struct packed {
    logic              start;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fps_cyc_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic              dq_oe;
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
  } fps_pins_t;

  typedef struct packed {
    logic              last;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fps_step_t;

endpackage

// ===== rtl/fps_bus_cycle.sv
// One flash bus cycle, write or read, on the parallel pins.
// Assumes the caller starts a new cycle only after the previous one reported done.
`timescale 1ns/10ps
module fps_bus_cycle (
  input  wire logic              i_mclk,
  input  wire logic              i_reset_n,
  input  wire fps_pkg::fps_cyc_t i_cyc,
  input  wire logic [15:0]       i_dq_in,
  output fps_pkg::fps_pins_t     o_pins,
  output logic                   o_done,
  output logic [15:0]            o_rdata
);
  import fps_pkg::*;

  typedef enum logic [1:0] {
    B_IDLE    = 2'b00,
    B_SETUP   = 2'b01,
    B_ACTIVE  = 2'b10,
    B_RECOVER = 2'b11
  } fps_bph_t;

  typedef struct packed {
    fps_bph_t          ph;
    logic [3:0]        cnt;
    logic              write;
    fps_pins_t         pins;
    logic              done;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] sync1;
    logic [DATA_W-1:0] sync2;
  } fps_bus_t;

  localparam fps_pins_t PINS_RST = '{addr: '0, dq_out: '0, dq_oe: 1'b0,
                                     ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};

  fps_bus_t s_q;
  fps_bus_t s_d;

  // ****************************************
  // Cycle sequencing
  // ****************************************
  always_comb begin
    s_d       = s_q;
    s_d.done  = 1'b0;
    // Data bus comes from another device; only sync2 is ever looked at
    s_d.sync1 = i_dq_in;
    s_d.sync2 = s_q.sync1;
    unique case (s_q.ph)
      B_IDLE: begin
        if (i_cyc.start) begin
          s_d.ph          = B_SETUP;
          s_d.write       = i_cyc.write;
          s_d.pins.addr   = i_cyc.addr;
          s_d.pins.dq_out = i_cyc.data;
          s_d.pins.dq_oe  = i_cyc.write;
          s_d.pins.ce_n   = 1'b0;
        end
      end
      B_SETUP: begin
        s_d.ph = B_ACTIVE;
        s_d.cnt = s_q.write ? WP_CYC : ACC_CYC;
        if (s_q.write) begin
          s_d.pins.we_n = 1'b0;
        end else begin
          s_d.pins.oe_n = 1'b0;
        end
      end
      B_ACTIVE: begin
        s_d.cnt = s_q.cnt - 4'h1;
        if (s_q.cnt == 4'h1) begin
          // Flash latches address and data on the rising write strobe
          s_d.ph        = B_RECOVER;
          s_d.cnt       = WPH_CYC;
          s_d.pins.we_n = 1'b1;
          s_d.pins.oe_n = 1'b1;
          if (!s_q.write) begin
            s_d.rdata = s_q.sync2;
          end
        end
      end
      B_RECOVER: begin
        s_d.cnt = s_q.cnt - 4'h1;
        if (s_q.cnt == 4'h1) begin
          s_d.ph         = B_IDLE;
          s_d.pins.ce_n  = 1'b1;
          s_d.pins.dq_oe = 1'b0;
          s_d.done       = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_q <= '{ph: B_IDLE, cnt: '0, write: 1'b0, pins: PINS_RST, done: 1'b0,
               rdata: '0, sync1: '0, sync2: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign o_pins  = s_q.pins;
  assign o_done  = s_q.done;
  assign o_rdata = s_q.rdata;

endmodule

// ===== rtl/fps_flash_host.sv
// Host-side sequencer for program suspend/resume, unlock bypass and
// accelerated programming of a parallel NOR flash.
// Assumes a single user issuing one request at a time on the request port.
//
// Contract
// (RQ1) Device halts programming within 15 us after suspend; host waits that long.
// (RQ2) Device updates status on suspend; host reports suspended only after the wait.
// (RQ3) Suspend is one write of 00B0h; address does not matter.
// (RQ4) While suspended, array reads go only to sectors other than the suspended one.
// (RQ5) Suspend also allowed in erase-suspended program; reads avoid both sectors. Code tracks no erase and blocks only the program-suspended sector.
// (RQ6) Identification query allowed while suspended; device returns to suspend after it.
// (RQ7) Resume is one write of 0030h, any address; programming then continues.
// (RQ8) Further resume writes after resuming are ignored by the device.
// (RQ9) After resume a new suspend may be issued.
// (RQ10) High voltage on the accelerate pin puts device in accelerated bypass.
// (RQ11) Abort recovery in bypass uses the full three-cycle reset.
// (RQ12) Removing high voltage after the program ends restores normal operation.
// (RQ13) Accelerated programming used at most ten times per sector.
// (RQ14) Sectors unlocked before high voltage; high voltage only for accelerated programs.
// (RQ15) Bypass word program is two writes without unlock cycles.
// (RQ16) In bypass only read, program, abort reset and bypass exit are valid.
// (RQ17) Bypass exit: 90h at sector address, then 00h; back to read mode.
// (RQ18) Bypass entry: 00AAh@555h, 0055h@2AAh, 0020h@555h.
// (RQ19) Bypass program: 00A0h setup at any address, then data at target.
// (RQ20) Writes that form no valid command in bypass or suspend change nothing.
`timescale 1ns/10ps
module fps_flash_host (
  input  wire logic              i_mclk,
  input  wire logic              i_reset_n,
  input  wire fps_pkg::fps_req_t i_req,
  input  wire logic [15:0]       i_dq_in,
  output logic                   o_ready,
  output fps_pkg::fps_rsp_t      o_rsp,
  output fps_pkg::fps_pins_t     o_pins,
  output logic                   o_accel_hv,
  output logic                   o_bypass,
  output logic                   o_suspended
);
  import fps_pkg::*;

  typedef enum logic [2:0] {
    M_IDLE      = 3'b000,
    M_HV_UP     = 3'b001,
    M_WRITE     = 3'b010,
    M_WAIT_WR   = 3'b011,
    M_SUSP_WAIT = 3'b100,
    M_READ_WAIT = 3'b101,
    M_POLL      = 3'b110,
    M_POLL_WAIT = 3'b111
  } fps_mst_t;

  typedef struct packed {
    fps_mst_t                      st;
    fps_op_t                       op;
    logic [ADDR_W-1:0]             addr;
    logic [DATA_W-1:0]             data;
    logic [1:0]                    step;
    logic [8:0]                    cnt;
    logic                          bypass;
    logic                          suspended;
    logic [SECT_W-1:0]             susp_sect;
    logic                          prog_busy;
    logic [ADDR_W-1:0]             prog_addr;
    logic [DATA_W-1:0]             prog_data;
    logic                          accel_hv;
    logic                          ready;
    fps_rsp_t                      rsp;
    fps_cyc_t                      cyc;
    logic [(1<<SECT_W)-1:0][3:0]   use_cnt;
  } fps_host_t;

  fps_host_t s_q;
  fps_host_t s_d;
  fps_pins_t bus_pins;
  logic      bus_done;
  logic [15:0] bus_rdata;

  function automatic logic [SECT_W-1:0] sect_of(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1 -: SECT_W];
  endfunction

  // ****************************************
  // Command cycle tables
  // ****************************************
  function automatic fps_step_t seq_step(input fps_op_t op, input logic [1:0] step,
                                         input logic [ADDR_W-1:0] a,
                                         input logic [DATA_W-1:0] d);
    fps_step_t s;
    logic [ADDR_W-1:0] sect_base;
    sect_base = {a[ADDR_W-1 -: SECT_W], (ADDR_W-SECT_W)'(0)};
    s = '{last: 1'b1, addr: a, data: d};
    unique case (op)
      OP_BYP_ENTER, OP_RESET3: begin
        // Full three cycles, never a shortened reset
        s.last = (step == 2'd2); // RQ11
        s.addr = (step == 2'd1) ? ADDR_UNLOCK2 : ADDR_UNLOCK1; // RQ18
        s.data = (step == 2'd0) ? CMD_UNLOCK1 : (step == 2'd1) ? CMD_UNLOCK2 :
                 (op == OP_BYP_ENTER) ? CMD_BYP_ENTRY : CMD_RESET; // RQ18
      end
      OP_BYP_PROG, OP_ACCEL_PROG: begin
        s.last = (step == 2'd1); // RQ15
        s.data = (step == 2'd0) ? CMD_PROG_SETUP : d; // RQ19
      end
      OP_BYP_EXIT: begin
        s.last = (step == 2'd1);
        s.addr = sect_base;
        s.data = (step == 2'd0) ? CMD_EXIT1 : CMD_EXIT2; // RQ17
      end
      OP_SUSPEND: s.data = CMD_SUSPEND; // RQ3
      OP_RESUME:  s.data = CMD_RESUME; // RQ7
      OP_READ:    s.data = d;
    endcase
    return s;
  endfunction

  // ****************************************
  // Request check and sequencing
  // ****************************************
  always_comb begin
    fps_step_t stp;
    logic      bad;
    logic      is_prog;
    stp = seq_step(s_q.op, s_q.step, s_q.addr, s_q.data);
    bad = 1'b0;
    is_prog = (i_req.op == OP_BYP_PROG) || (i_req.op == OP_ACCEL_PROG);
    s_d = s_q;
    s_d.rsp.done  = 1'b0;
    s_d.rsp.err   = 1'b0;
    s_d.cyc.start = 1'b0;
    unique case (s_q.st)
      M_IDLE: begin
        s_d.ready = 1'b1;
        if (i_req.valid && s_q.ready) begin
          unique case (i_req.op)
            // Only sectors outside the suspended one are read
            OP_READ:       bad = s_q.suspended &&
                                 (sect_of(i_req.addr) == s_q.susp_sect); // RQ4 RQ5
            OP_BYP_ENTER:  bad = s_q.bypass || s_q.suspended; // RQ20
            OP_BYP_PROG:   bad = !s_q.bypass; // RQ16
            OP_BYP_EXIT:   bad = !s_q.bypass || s_q.suspended; // RQ16
            OP_SUSPEND:    bad = !s_q.prog_busy || s_q.suspended; // RQ9 RQ20
            OP_RESUME:     bad = !s_q.suspended; // RQ8
            OP_RESET3:     bad = s_q.suspended; // RQ20
            OP_ACCEL_PROG: bad = (s_q.use_cnt[sect_of(i_req.addr)] >= ACCEL_USE_MAX); // RQ13
          endcase
          if (is_prog && (s_q.suspended || s_q.prog_busy)) begin
            bad = 1'b1; // RQ20
          end
          s_d.ready = 1'b0;
          s_d.op    = i_req.op;
          s_d.addr  = i_req.addr;
          s_d.data  = i_req.data;
          s_d.step  = 2'd0;
          if (bad) begin
            s_d.rsp.done = 1'b1;
            s_d.rsp.err  = 1'b1;
          end else if (i_req.op == OP_READ) begin
            s_d.st        = M_READ_WAIT;
            s_d.cyc       = '{start: 1'b1, write: 1'b0, addr: i_req.addr, data: '0};
          end else if (i_req.op == OP_ACCEL_PROG) begin
            // Raise the high voltage only for this program
            s_d.st       = M_HV_UP;
            s_d.accel_hv = 1'b1; // RQ10 RQ14
            s_d.cnt      = HV_CYC;
          end else begin
            s_d.st = M_WRITE;
          end
        end
      end
      M_HV_UP: begin
        s_d.cnt = s_q.cnt - 9'h1;
        if (s_q.cnt == 9'h1) begin
          s_d.st = M_WRITE;
        end
      end
      M_WRITE: begin
        s_d.cyc = '{start: 1'b1, write: 1'b1, addr: stp.addr, data: stp.data};
        s_d.st  = M_WAIT_WR;
      end
      M_WAIT_WR: begin
        if (bus_done && !stp.last) begin
          s_d.step = s_q.step + 2'd1;
          s_d.st   = M_WRITE;
        end else if (bus_done) begin
          s_d.st       = M_IDLE;
          s_d.ready    = 1'b1;
          s_d.rsp.done = 1'b1;
          unique case (s_q.op)
            OP_BYP_ENTER: s_d.bypass = 1'b1; // RQ18
            OP_BYP_EXIT:  s_d.bypass = 1'b0; // RQ17
            OP_RESET3:    s_d.prog_busy = 1'b0; // RQ11
            OP_RESUME:    s_d.suspended = 1'b0; // RQ7
            OP_SUSPEND: begin
              // Status is trusted only after the worst-case halt time
              s_d.st    = M_SUSP_WAIT;
              s_d.ready = 1'b0;
              s_d.rsp.done = 1'b0;
              s_d.cnt   = SUSPEND_CYC; // RQ1
            end
            OP_BYP_PROG, OP_ACCEL_PROG: begin
              s_d.prog_busy = 1'b1;
              s_d.prog_addr = s_q.addr;
              s_d.prog_data = s_q.data;
              if (s_q.op == OP_ACCEL_PROG) begin
                s_d.st       = M_POLL;
                s_d.ready    = 1'b0;
                s_d.rsp.done = 1'b0;
              end
            end
            OP_READ: s_d.st = M_IDLE;
          endcase
        end
      end
      M_SUSP_WAIT: begin
        s_d.cnt = s_q.cnt - 9'h1;
        if (s_q.cnt == 9'h1) begin
          s_d.st        = M_IDLE;
          s_d.ready     = 1'b1;
          s_d.rsp.done  = 1'b1;
          s_d.suspended = 1'b1; // RQ2
          s_d.susp_sect = sect_of(s_q.prog_addr);
        end
      end
      M_READ_WAIT: begin
        if (bus_done) begin
          s_d.st        = M_IDLE;
          s_d.ready     = 1'b1;
          s_d.rsp.done  = 1'b1;
          s_d.rsp.rdata = bus_rdata;
          if (s_q.prog_busy && !s_q.suspended && (s_q.addr == s_q.prog_addr) &&
              (bus_rdata[DQ_POLL_BIT] == s_q.prog_data[DQ_POLL_BIT])) begin
            s_d.prog_busy = 1'b0;
          end
        end
      end
      M_POLL: begin
        s_d.cyc = '{start: 1'b1, write: 1'b0, addr: s_q.addr, data: '0};
        s_d.st  = M_POLL_WAIT;
      end
      M_POLL_WAIT: begin
        if (bus_done && (bus_rdata[DQ_POLL_BIT] != s_q.data[DQ_POLL_BIT])) begin
          s_d.st = M_POLL;
        end else if (bus_done) begin
          // Program finished: drop the high voltage and count the use
          s_d.accel_hv  = 1'b0; // RQ12
          s_d.prog_busy = 1'b0;
          s_d.use_cnt[sect_of(s_q.addr)] = s_q.use_cnt[sect_of(s_q.addr)] + 4'h1; // RQ13
          s_d.st        = M_IDLE;
          s_d.ready     = 1'b1;
          s_d.rsp.done  = 1'b1;
          s_d.rsp.rdata = bus_rdata;
        end
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_q <= '{st: M_IDLE, op: OP_READ, addr: '0, data: '0, step: '0, cnt: '0,
               bypass: 1'b0, suspended: 1'b0, susp_sect: '0, prog_busy: 1'b0,
               prog_addr: '0, prog_data: '0, accel_hv: 1'b0, ready: 1'b0,
               rsp: '0, cyc: '0, use_cnt: {(1<<SECT_W){ACCEL_USE_RST}}};
    end else begin
      s_q <= s_d;
    end
  end

  fps_bus_cycle u_bus (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_cyc     (s_q.cyc),
    .i_dq_in   (i_dq_in),
    .o_pins    (bus_pins),
    .o_done    (bus_done),
    .o_rdata   (bus_rdata)
  );

  assign o_pins      = bus_pins;
  assign o_ready     = s_q.ready;
  assign o_rsp       = s_q.rsp;
  assign o_accel_hv  = s_q.accel_hv;
  assign o_bypass    = s_q.bypass;
  assign o_suspended = s_q.suspended;

endmodule

// ===== tb/fps_host_properties.sv
// Port checks for the flash command sequencer.
// Assumes it is bound to fps_flash_host.
`timescale 1ns/10ps
module fps_host_props (
  input wire logic               i_mclk,
  input wire logic               i_reset_n,
  input wire fps_pkg::fps_req_t  i_req,
  input wire logic [15:0]        i_dq_in,
  input wire logic               o_ready,
  input wire fps_pkg::fps_rsp_t  o_rsp,
  input wire fps_pkg::fps_pins_t o_pins,
  input wire logic               o_accel_hv,
  input wire logic               o_bypass,
  input wire logic               o_suspended
);
  import fps_pkg::*;
  logic        we_q;
  logic [15:0] wd_q;
  logic [9:0]  we_age_q;
  logic [9:0]  hv_age_q;
  // Last written word and the age of the last write strobe and high voltage
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      we_q     <= 1'b1;
      wd_q     <= 16'h0000;
      we_age_q <= 10'h000;
      hv_age_q <= 10'h000;
    end else begin
      we_q     <= o_pins.we_n;
      if (!we_q && o_pins.we_n) wd_q <= o_pins.dq_out;
      we_age_q <= !o_pins.we_n ? 10'h000 : we_age_q + {9'h000, we_age_q != 10'h3ff};
      hv_age_q <= o_accel_hv ? 10'h000 : hv_age_q + {9'h000, hv_age_q != 10'h3ff};
    end
  end
  // ****
  // Properties
  // ****
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  a_err_with_done: assert property (o_rsp.err |-> o_rsp.done)
    else $error("err without done");
  a_refuse_quiet: assert property (o_rsp.err |-> o_pins.ce_n && $past(o_pins.ce_n))
    else $error("refused request moved pins");
  a_suspend_wait: assert property ($rose(o_suspended) |-> we_age_q >= 10'd295)
    else $error("suspended flagged too early");
  a_suspend_word: assert property ($rose(o_suspended) |-> wd_q == CMD_SUSPEND)
    else $error("suspend without suspend word");
  a_resume_word: assert property ($fell(o_suspended) |-> wd_q == CMD_RESUME)
    else $error("resume without resume word");
  a_entry_word: assert property ($rose(o_bypass) && !o_accel_hv |-> wd_q == CMD_BYP_ENTRY)
    else $error("bypass without entry word");
  a_exit_word: assert property ($fell(o_bypass) && hv_age_q > 10'd20 |-> wd_q == CMD_EXIT2)
    else $error("bypass left without exit word");
  a_hv_settle: assert property ($rose(o_accel_hv) |-> o_pins.we_n [*5])
    else $error("write too soon after high voltage");
  a_hv_no_susp: assert property (o_accel_hv |-> !o_suspended)
    else $error("high voltage while suspended");
  a_write_walk: assert property ($fell(o_pins.we_n) |-> !o_pins.ce_n && o_pins.dq_oe
    ##1 o_pins.we_n ##1 o_pins.ce_n && !o_pins.dq_oe)
    else $error("write cycle shape wrong");
  a_no_fight: assert property (!o_pins.oe_n |-> !o_pins.dq_oe)
    else $error("data bus driven during read");
  c_suspend: cover property ($rose(o_suspended));
  c_exit: cover property ($fell(o_bypass));
  c_accel: cover property ($rose(o_accel_hv));
  c_refuse: cover property (o_rsp.err);
endmodule
bind fps_flash_host fps_host_props u_props (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
  .i_req(i_req), .i_dq_in(i_dq_in), .o_ready(o_ready), .o_rsp(o_rsp), .o_pins(o_pins),
  .o_accel_hv(o_accel_hv), .o_bypass(o_bypass), .o_suspended(o_suspended));

// ===== tb/fps_flash_model.sv
// Behavioural flash: decodes write cycles, programs after a delay, answers reads.
// Assumes registered host pins, sampled on the host clock.
`timescale 1ns/10ps
module fps_flash_model #(
  parameter int PROG_CYC = 40
) (
  input  wire logic               i_mclk,
  input  wire fps_pkg::fps_pins_t i_pins,
  input  wire logic               i_hv,
  output logic [15:0]             o_dq
);
  import fps_pkg::*;
  logic        we_q = 1'b1;
  logic        byp = 1'b0, acc = 1'b0, setup = 1'b0, exitp = 1'b0, busy = 1'b0, susp = 1'b0;
  logic [1:0]  ul = 2'h0;
  logic [25:0] pa = '0;
  logic [15:0] pd = '0, last = '0, val;
  int          cnt = 0, n_acc = 0;
  logic [41:0] wq[$];
  wire         drive = !i_pins.ce_n && !i_pins.oe_n;
  always_comb begin
    if (i_pins.addr == pa) val = busy ? pd ^ 16'h0080 : pd;
    else val = i_pins.addr[15:0] ^ 16'ha5a5;
  end
  // Released bus shows the inverse of the last value, never a stale copy
  assign o_dq = drive ? val : ~last;
  task automatic take(input logic [25:0] a, input logic [15:0] d);
    wq.push_back({a, d});
    // Anything but resume, a query included, leaves the program suspended
    if (susp) susp = (d != CMD_RESUME);
    else if (busy) susp = (d == CMD_SUSPEND);
    else if (setup) begin
      pa = a; pd = d; busy = 1'b1; cnt = 0; setup = 1'b0; n_acc += acc;
    end else if (exitp) begin
      exitp = 1'b0; byp = byp && (d != CMD_EXIT2);
    end else if (byp && d == CMD_PROG_SETUP) setup = 1'b1;
    else if (byp && d == CMD_EXIT1) exitp = 1'b1;
    else if (ul == 2'h0) ul = {1'b0, a == ADDR_UNLOCK1 && d == CMD_UNLOCK1};
    else if (ul == 2'h1) ul = (a == ADDR_UNLOCK2 && d == CMD_UNLOCK2) ? 2'h2 : 2'h0;
    else begin
      ul = 2'h0; byp = byp || (a == ADDR_UNLOCK1 && d == CMD_BYP_ENTRY);
    end
  endtask
  always @(posedge i_mclk) begin
    we_q <= i_pins.we_n;
    if (drive) last <= val;
    // Suspend halts at once, well inside the allowed bound
    if (busy && !susp) begin
      busy = (cnt < PROG_CYC);
      cnt++;
    end
    if (i_hv && !byp) begin
      byp = 1'b1; acc = 1'b1;
    end
    if (!i_hv && acc && !busy) begin
      byp = 1'b0; acc = 1'b0;
    end
    if (!we_q && i_pins.we_n && !i_pins.ce_n) take(i_pins.addr, i_pins.dq_out);
  end
endmodule

// ===== tb/flash_program_suspend_bypass_cmds_test.sv
// Self-checking bench for the flash command sequencer.
// Assumes the flash model's write log and state are reachable by name.
`timescale 1ns/10ps
module flash_program_suspend_bypass_cmds_test;
  import fps_pkg::*;
  localparam logic [25:0] PA = 26'h0012345;
  localparam logic [15:0] PD = 16'h1234;
  logic        i_mclk, i_reset_n, o_ready, o_accel_hv, o_bypass, o_suspended, e;
  fps_req_t    i_req;
  fps_rsp_t    o_rsp;
  fps_pins_t   o_pins;
  logic [15:0] i_dq_in, rd;
  int          failures = 0, n_checks = 0, cyc;
  fps_flash_host dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_req(i_req),
    .i_dq_in(i_dq_in), .o_ready(o_ready), .o_rsp(o_rsp), .o_pins(o_pins),
    .o_accel_hv(o_accel_hv), .o_bypass(o_bypass), .o_suspended(o_suspended));
  fps_flash_model #(.PROG_CYC(40)) flash (.i_mclk(i_mclk), .i_pins(o_pins),
    .i_hv(o_accel_hv), .o_dq(i_dq_in));
  // ****
  // Helpers
  // ****
  task automatic chk(input logic [41:0] got, input logic [41:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chb(input logic got, input logic exp);
    chk({41'h0, got}, {41'h0, exp});
  endtask
  task automatic wr(input logic [25:0] a, input logic [15:0] d);
    logic [41:0] g;
    g = '1;
    if (flash.wq.size() > 0) g = flash.wq.pop_front();
    chk(g, {a, d});
  endtask
  // Request held from a falling edge until an edge sees ready, then answer awaited
  task automatic req(input fps_op_t op, input logic [25:0] a, input logic [15:0] d);
    @(negedge i_mclk);
    i_req = '{valid: 1'b1, op: op, addr: a, data: d};
    @(posedge i_mclk);
    while (o_ready !== 1'b1) @(posedge i_mclk);
    @(negedge i_mclk);
    i_req.valid = 1'b0;
    cyc = 0;
    while (o_rsp.done !== 1'b1 && cyc < 4000) begin
      @(negedge i_mclk);
      cyc++;
    end
    // A request that never answers is a mismatch, not a silent pass
    chb(cyc < 4000, 1'b1);
    e = o_rsp.err;
    rd = o_rsp.rdata;
  endtask
  task automatic rq(input fps_op_t op, input logic [25:0] a, input logic xe);
    req(op, a, PD);
    chb(e, xe);
  endtask
  task automatic poll(input logic [25:0] a, input logic [15:0] d);
    rd = 'x;
    for (int i = 0; i < 40 && rd !== d; i++) req(OP_READ, a, d);
    chk({26'h0, rd}, {26'h0, d});
  endtask
  task automatic empty();
    chk(42'(flash.wq.size()), 42'h0);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_entry();
    rq(OP_BYP_ENTER, 26'h0, 1'b0);
    wr(ADDR_UNLOCK1, CMD_UNLOCK1);
    wr(ADDR_UNLOCK2, CMD_UNLOCK2);
    wr(ADDR_UNLOCK1, CMD_BYP_ENTRY);
    chb(o_bypass & flash.byp, 1'b1);
    rq(OP_BYP_ENTER, 26'h0, 1'b1);
    empty();
    $display("test entry finished");
  endtask
  task automatic t_suspend();
    req(OP_BYP_PROG, PA, PD);
    wr(PA, CMD_PROG_SETUP);
    wr(PA, PD);
    rq(OP_BYP_PROG, PA + 26'h1, 1'b1);
    rq(OP_SUSPEND, 26'h3ffffff, 1'b0);
    wr(26'h3ffffff, CMD_SUSPEND);
    chb(cyc >= 300, 1'b1);
    chb(o_suspended & flash.susp, 1'b1);
    rq(OP_READ, 26'h0050010, 1'b0);
    chk({26'h0, rd}, {26'h0, 16'h0010 ^ 16'ha5a5});
    rq(OP_READ, PA, 1'b1);
    rq(OP_SUSPEND, PA, 1'b1);
    rq(OP_BYP_PROG, PA, 1'b1);
    rq(OP_RESET3, PA, 1'b1);
    empty();
    rq(OP_RESUME, 26'h0000777, 1'b0);
    wr(26'h0000777, CMD_RESUME);
    chb(o_suspended | flash.susp, 1'b0);
    rq(OP_RESUME, PA, 1'b1);
    rq(OP_SUSPEND, PA, 1'b0);
    wr(PA, CMD_SUSPEND);
    rq(OP_RESUME, PA, 1'b0);
    wr(PA, CMD_RESUME);
    poll(PA, PD);
    $display("test suspend finished");
  endtask
  task automatic t_reset_exit();
    rq(OP_RESET3, 26'h0, 1'b0);
    wr(ADDR_UNLOCK1, CMD_UNLOCK1);
    wr(ADDR_UNLOCK2, CMD_UNLOCK2);
    wr(ADDR_UNLOCK1, CMD_RESET);
    rq(OP_BYP_EXIT, 26'h0345678, 1'b0);
    wr(26'h0340000, CMD_EXIT1);
    wr(26'h0340000, CMD_EXIT2);
    chb(o_bypass | flash.byp, 1'b0);
    rq(OP_BYP_PROG, PA, 1'b1);
    rq(OP_BYP_EXIT, PA, 1'b1);
    empty();
    $display("test reset and exit finished");
  endtask
  task automatic t_accel();
    logic [25:0] a;
    logic [15:0] d;
    for (int k = 0; k < 11; k++) begin
      a = 26'h0200000 + 26'(k);
      d = 16'h0081 + 16'(k * 3);
      req(OP_ACCEL_PROG, a, d);
      chb(e, k == 10);
      if (k < 10) begin
        wr(a, CMD_PROG_SETUP);
        wr(a, d);
        @(negedge i_mclk);
        chb(o_accel_hv | flash.byp, 1'b0);
      end
    end
    chk(42'(flash.n_acc), 42'd10);
    empty();
    $display("test accel finished");
  endtask
  // ****
  // Run control
  // ****
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end
  initial begin
    repeat (20000) @(posedge i_mclk);
    failures++;
    report_and_stop();
  end
  initial begin
    i_reset_n = 1'b0;
    i_req = '0;
    repeat (20) @(posedge i_mclk);
    @(negedge i_mclk);
    i_reset_n = 1'b1;
    @(negedge i_mclk);
    t_entry();
    t_suspend();
    t_reset_exit();
    t_accel();
    report_and_stop();
  end
endmodule
